// >>> bench/phs_periph.sv
// far-side peripheral: data source, strobes and acks, pull-ups on every line
`timescale 1ns/1ns
module phs_periph (
	input wire i_clock,
	input wire [7:0] i_port_a,
	input wire [7:0] i_port_a_oe,
	input wire [7:0] i_port_b,
	input wire [7:0] i_port_b_oe,
	input wire [7:0] i_port_c,
	input wire [7:0] i_port_c_oe,
	output wire [7:0] o_pin_a,
	output wire [7:0] o_pin_b,
	output wire [7:0] o_pin_c
);
	reg [7:0] da = 8'hFF;
	reg [7:0] db = 8'hFF;
	reg [7:0] dc = 8'hFF;
	// wire level: device drive where enabled, else peripheral or pull-up
	assign o_pin_a = (i_port_a_oe & i_port_a) | (~i_port_a_oe & da);
	assign o_pin_b = (i_port_b_oe & i_port_b) | (~i_port_b_oe & db);
	assign o_pin_c = (i_port_c_oe & i_port_c) | (~i_port_c_oe & dc);
	// strobe with data held around it
	task strobe(input int n, input [7:0] d);
		@(posedge i_clock);
		if (n == 4)
			da <= d;
		else
			db <= d;
		repeat (2) @(posedge i_clock);
		dc[n] <= 1'b0;
		repeat (3) @(posedge i_clock);
		dc[n] <= 1'b1;
		repeat (4) @(posedge i_clock);
		da <= 8'hFF;
		db <= 8'hFF;
	endtask
	task ack(input int n);
		@(posedge i_clock);
		dc[n] <= 1'b0;
		repeat (3) @(posedge i_clock);
		dc[n] <= 1'b1;
		repeat (4) @(posedge i_clock);
	endtask
endmodule // phs_periph

// >>> bench/phs_port_props.sv
// bus and pin assertions for the parallel handshake port
`timescale 1ns/1ns
module phs_port_props (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	input wire [31:0] o_hrdata,
	input wire o_hreadyout,
	input wire o_hresp,
	input wire [7:0] i_port_c,
	input wire [7:0] o_port_a,
	input wire [7:0] o_port_a_oe,
	input wire [7:0] o_port_b_oe,
	input wire [7:0] o_port_c,
	input wire [7:0] o_port_c_oe
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	reg ph_wr;
	reg [3:0] ph_adr;
	reg [7:0] mode;
	reg [2:0] since;
	wire wr_ctl = ph_wr && ph_adr == 4'hC;
	wire in_a = mode[6:5] == 2'b01 && mode[4];
	wire out_a = mode[6:5] == 2'b01 && !mode[4];
	wire basic = mode[6:5] == 2'b00 && !mode[2];
	// follow write data phases, the mode word and its settling time
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			ph_wr <= 1'b0;
			ph_adr <= 4'h0;
			mode <= 8'h9B;
			since <= 3'h0;
		end else begin
			ph_wr <= i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr[31:4] == 28'h0;
			ph_adr <= i_haddr[3:0];
			if (wr_ctl && i_hwdata[7])
				mode <= i_hwdata[7:0];
			if (wr_ctl)
				since <= 3'h0;
			else if (since != 3'h7)
				since <= since + 3'h1;
		end
	end
	sequence stb_a_fall;
		in_a && since == 3'h7 ##0 $fell(i_port_c[4]);
	endsequence
	sequence wr_data_a;
		out_a && ph_wr && ph_adr == 4'h0;
	endsequence
	a_ready_high: assert property (o_hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!o_hresp) else $error("error response");
	a_rdata_byte: assert property (o_hrdata[31:8] == 24'h0) else $error("read data upper bits set");
	a_basic_dir: assert property (since == 3'h7 && basic |-> o_port_a_oe == {8{~mode[4]}} &&
		o_port_b_oe == {8{~mode[1]}} && o_port_c_oe == {{4{~mode[3]}}, {4{~mode[0]}}}) else $error("basic direction");
	a_mode_clears: assert property (wr_ctl && i_hwdata[7] |-> ##[1:3] o_port_a == 8'h00)
		else $error("mode word left output latch");
	a_in_lines_a: assert property (since == 3'h7 && in_a |-> o_port_c_oe[5:3] == 3'b101)
		else $error("group a input lines");
	a_in_lines_b: assert property (since == 3'h7 && mode[2] && mode[1] |-> o_port_c_oe[2:0] == 3'b011)
		else $error("group b input lines");
	a_out_lines_a: assert property (since == 3'h7 && out_a |-> o_port_c_oe[7:6] == 2'b10 && o_port_c_oe[3])
		else $error("group a output lines");
	a_full_after_stb: assert property (stb_a_fall |-> ##[2:8] o_port_c[5]) else $error("buffer full not set");
	a_obf_on_write: assert property (wr_data_a |-> ##[1:3] !o_port_c[7]) else $error("output full not low");
endmodule // phs_port_props
bind phs_port phs_port_props u_props (.*);

// >>> bench/tb.sv
// self-checking bench for the parallel handshake port
`timescale 1ns/1ns
module tb;
	reg i_clock = 1'b0;
	reg i_rst_n = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'b00;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg [7:0] rv;
	wire [31:0] hrdata;
	wire hready;
	wire [7:0] oa, oa_oe, ob, ob_oe, oc, oc_oe, pin_a, pin_b, pin_c;
	int error_cnt = 0;
	int checks = 0;
	int k;
	phs_port DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(), .i_port_a(pin_a), .o_port_a(oa), .o_port_a_oe(oa_oe),
		.i_port_b(pin_b), .o_port_b(ob), .o_port_b_oe(ob_oe), .i_port_c(pin_c), .o_port_c(oc), .o_port_c_oe(oc_oe));
	phs_periph u_per (.i_clock(i_clock), .i_port_a(oa), .i_port_a_oe(oa_oe), .i_port_b(ob), .i_port_b_oe(ob_oe),
		.i_port_c(oc), .i_port_c_oe(oc_oe), .o_pin_a(pin_a), .o_pin_b(pin_b), .o_pin_c(pin_c));
	// 20 mhz clock
	initial begin
		forever #25 i_clock = ~i_clock;
	end
	// single ahb-lite transfer, read byte lands in rv
	task xfer(input [7:0] a, input w, input [7:0] d);
		@(posedge i_clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge i_clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge i_clock); while (hready !== 1'b1);
		rv = hrdata[7:0];
	endtask
	task wr(input [7:0] a, input [7:0] d);
		xfer(a, 1'b1, d);
	endtask
	task rd(input [7:0] a);
		xfer(a, 1'b0, 8'h00);
	endtask
	task chk(input string nm, input [7:0] e, input [7:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// control reads, unmapped space, reset state
	task t_bus;
		rd(8'h0C);
		chk("control read", 8'h00, rv);
		wr(8'h10, 8'h55);
		rd(8'h10);
		chk("unmapped read", 8'h00, rv);
		rd(8'h08);
		chk("reset port c", 8'hFF, rv);
		$display("bus test done");
	endtask
	// every basic direction set, latched outputs, live inputs
	task t_basic;
		reg [7:0] m;
		for (k = 0; k < 16; k++) begin
			m = {3'b100, k[3], k[2], 1'b0, k[1], k[0]};
			wr(8'h0C, m);
			repeat (2) @(posedge i_clock);
			chk("oe a", {8{~m[4]}}, oa_oe);
			chk("oe b", {8{~m[1]}}, ob_oe);
			chk("oe c", {{4{~m[3]}}, {4{~m[0]}}}, oc_oe);
		end
		wr(8'h0C, 8'h80);
		wr(8'h04, 8'hC3);
		wr(8'h08, 8'h96);
		repeat (2) @(posedge i_clock);
		chk("pin b", 8'hC3, ob);
		chk("pin c", 8'h96, oc);
		wr(8'h0C, 8'h98);
		u_per.da <= 8'h11;
		u_per.dc <= 8'h3C;
		repeat (4) @(posedge i_clock);
		chk("pin b cleared", 8'h00, ob);
		rd(8'h00);
		chk("live a", 8'h11, rv);
		u_per.da <= 8'h22;
		repeat (4) @(posedge i_clock);
		rd(8'h00);
		chk("live a again", 8'h22, rv);
		rd(8'h08);
		chk("mixed c", 8'h30, rv);
		u_per.da <= 8'hFF;
		u_per.dc <= 8'hFF;
		$display("basic test done");
	endtask
	// single bit set and clear of port c
	task t_bits;
		wr(8'h0C, 8'h80);
		for (k = 0; k < 8; k++)
			wr(8'h0C, {4'h0, k[2:0], 1'b1});
		wr(8'h0C, 8'h06);
		repeat (2) @(posedge i_clock);
		chk("bit set c", 8'hF7, oc);
		chk("mode kept", 8'hFF, oa_oe);
		$display("bit test done");
	endtask
	// strobed input: idle status, capture, poll, read, clear
	task t_in(input [7:0] m, input [7:0] en, input int n, input [7:0] pt, input [7:0] d, input [7:0] ef,
		input [7:0] ee);
		wr(8'h0C, m);
		rd(8'h08);
		chk("idle status", 8'h00, rv);
		wr(8'h08, 8'hC0);
		wr(8'h0C, en);
		u_per.strobe(n, d);
		for (k = 0; k < 20 && (rv & ef & 8'h22) == 8'h00; k++)
			rd(8'h08);
		chk("full status", ef, rv);
		chk("full pins", ef & 8'h2B, oc & 8'h2B);
		rd(pt);
		chk("strobed data", d, rv);
		rd(8'h08);
		chk("after read", ee, rv);
		$display("strobed input test done");
	endtask
	// strobed output: full flag low on write, high on ack
	task t_out(input [7:0] m, input [7:0] pt, input [7:0] d, input int n, input [7:0] en, input [7:0] fm,
		input [7:0] ex);
		wr(8'h0C, m);
		rd(8'h08);
		chk("empty flag", fm, rv & fm);
		wr(pt, d);
		rd(8'h08);
		chk("full flag", 8'h00, rv & fm);
		rd(pt);
		chk("output latch", d, rv);
		u_per.ack(n);
		wr(8'h0C, en);
		rd(8'h08);
		chk("output status", ex, rv);
		$display("strobed output test done");
	endtask
	// reset, then the scenarios
	initial begin
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		t_bus;
		t_basic;
		t_bits;
		t_in(8'hB0, 8'h09, 4, 8'h00, 8'hA5, 8'hF8, 8'hD0);
		t_in(8'h86, 8'h05, 2, 8'h04, 8'h3C, 8'hC7, 8'hC4);
		t_out(8'hA0, 8'h00, 8'h77, 6, 8'h0D, 8'h80, 8'hC8);
		t_out(8'h84, 8'h04, 8'h5A, 2, 8'h05, 8'h02, 8'h07);
		test_done;
	end
	// watchdog: tests need about 300 cycles
	initial begin
		#500000;
		error_cnt++;
		test_done;
	end
endmodule // tb

// >>> core/phs_defs.vh
// constants of the parallel handshake port
// Summary of operation
// R1 - control word with bit 7 set is a mode word for all groups
// R2 - basic mode direction bits: 4 port A, 3 upper C, 1 port B, 0 lower C; set means input
// R3 - basic mode gives two byte ports and two independent C nibbles
// R4 - basic mode outputs are latched, inputs read live pins
// R5 - basic mode has no handshake; writes and reads act directly
// R6 - strobed mode: group A is port A plus upper C, group B port B plus lower C
// R7 - strobed data port latches both as input and as output
// R8 - mode word B0 gives port A strobed input with upper C handshake
// R9 - bits 7, 2, 1 set give port B strobed input, no spare C lines
// R10 - port A strobed input leaves C lines 6 and 7 as plain I/O
// R11 - strobed input C lines: 5 full A, 4 strobe A, 3 request A, 2 strobe B, 1 full B, 0 request B
// R12 - strobed input C read: spares, full A, enable A, request A, enable B, full B, request B
// R13 - strobe input levels never appear in the C status word
// R14 - buffer full sets once strobed data sits in the input latch
// R15 - host polls buffer full before reading the data port
// R16 - each strobed port requests interrupt while enabled and full; both visible in status; output groups here request while enabled and empty
// R17 - single C bits set or cleared by a control word without bit 7
// R18 - port A strobed output leaves C lines 4 and 5 as plain I/O
// R19 - bits 7, 2 set and bit 1 clear give port B strobed output, no spares
// R20 - strobed output status layout differs from strobed input layout
// R21 - bit 7 clear: bits 3..1 pick the C bit, bit 0 is its value
// R22 - strobed output C lines: 7 full A low, 6 ack A, 3 request A, 2 ack B, 1 full B low, 0 request B
// R23 - output full flag goes low on host data write, high again on acknowledge
// R24 - mode bits 6..5 group A mode, bit 2 group B mode
// R25 - strobe loads latch and sets full; data port read clears full and request
// R26 - any mode word clears output latches, flags and interrupt enables
`ifndef PHS_DEFS_VH
`define PHS_DEFS_VH
// register byte offsets
`define PHS_OFS_PORT_A 4'h0
`define PHS_OFS_PORT_B 4'h4
`define PHS_OFS_PORT_C 4'h8
`define PHS_OFS_CTRL 4'hC
// control word fields
`define PHS_CW_FLAG 7
`define PHS_CW_GA_MODE_HI 6
`define PHS_CW_GA_MODE_LO 5
`define PHS_CW_DIR_A 4
`define PHS_CW_DIR_CU 3
`define PHS_CW_GB_MODE 2
`define PHS_CW_DIR_B 1
`define PHS_CW_DIR_CL 0
`define PHS_CW_BIT_VAL 0
// reset mode word: basic mode, everything input
`define PHS_MODE_RESET 8'h9B
// port C line positions used by handshakes
`define PHS_C_FULL_A_IN 5
`define PHS_C_STB_A 4
`define PHS_C_REQ_A 3
`define PHS_C_STB_B 2
`define PHS_C_FULL_B 1
`define PHS_C_REQ_B 0
`define PHS_C_FULL_A_OUT 7
`define PHS_C_ACK_A 6
`define PHS_C_ACK_B 2
// bit set/reset selects that carry the interrupt enables
`define PHS_BSR_ENA_IN 3'd4
`define PHS_BSR_ENA_OUT 3'd6
`define PHS_BSR_ENB 3'd2
`endif

// >>> core/phs_port.v
// parallel handshake port with an ahb-lite register slave
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`include "phs_defs.vh"
module phs_port (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output reg o_hreadyout,
	output reg o_hresp,
	input wire [7:0] i_port_a,
	output reg [7:0] o_port_a,
	output reg [7:0] o_port_a_oe,
	input wire [7:0] i_port_b,
	output reg [7:0] o_port_b,
	output reg [7:0] o_port_b_oe,
	input wire [7:0] i_port_c,
	output reg [7:0] o_port_c,
	output reg [7:0] o_port_c_oe
);

	// configuration and latches
	// pin enables elsewhere are high while the device drives the line
	reg [7:0] mode_word;
	reg [7:0] out_a;
	reg [7:0] out_b;
	reg [7:0] out_c;
	reg [7:0] in_latch_a;
	reg [7:0] in_latch_b;
	reg input_full_grp_a;
	reg input_full_grp_b;
	reg output_full_grp_a_n;
	reg output_full_grp_b_n;
	reg irq_enable_grp_a;
	reg irq_enable_grp_b;
	// two-stage pin synchronisers, third stage for edges
	reg [7:0] a_s1;
	reg [7:0] a_s2;
	reg [7:0] b_s1;
	reg [7:0] b_s2;
	reg [7:0] c_s1;
	reg [7:0] c_s2;
	reg [7:0] c_s3;
	// ahb data phase state, then combinational pin, status and read values
	reg wr_pend;
	reg [3:0] wr_ofs;
	reg [7:0] next_c_out;
	reg [7:0] next_c_oe;
	reg [7:0] next_a_oe;
	reg [7:0] next_b_oe;
	reg [7:0] status_c;
	reg [7:0] rd_val;

	// falling edge of a synchronised line: older stage high, newer low
	function phs_fall;
		input older;
		input newer;
		begin
			phs_fall = older & ~newer;
		end
	endfunction

	// interrupt request of one group: enabled and its buffer condition holds
	function phs_irq;
		input enable;
		input dir_in;
		input in_full;
		input out_full_n;
		begin
			// output side requests once the buffer is empty again
			phs_irq = enable & (dir_in ? in_full : out_full_n);
		end
	endfunction

	// register offset match, shared by the read and write decoders
	function phs_hit;
		input [3:0] got;
		input [3:0] want;
		begin
			phs_hit = (got == want);
		end
	endfunction

	// decoded modes
	// R24 group A mode bits 6..5, group B mode bit 2
	// the bidirectional code 1x is treated as strobed and goes no further
	wire ga_strobed = mode_word[`PHS_CW_GA_MODE_HI] | mode_word[`PHS_CW_GA_MODE_LO];
	wire gb_strobed = mode_word[`PHS_CW_GB_MODE];
	// R8 bit 4 with strobed group A gives strobed input
	// direction bits are read in basic and strobed mode alike
	wire dir_a_in = mode_word[`PHS_CW_DIR_A];
	wire dir_b_in = mode_word[`PHS_CW_DIR_B];
	wire dir_cu_in = mode_word[`PHS_CW_DIR_CU];
	wire dir_cl_in = mode_word[`PHS_CW_DIR_CL];
	// handshake lines as seen after the two-stage synchroniser
	wire strobe_in_grp_a_n = c_s2[`PHS_C_STB_A];
	wire strobe_in_grp_b_n = c_s2[`PHS_C_STB_B];
	wire acknowledge_grp_a_n = c_s2[`PHS_C_ACK_A];
	wire acknowledge_grp_b_n = c_s2[`PHS_C_ACK_B];
	// edges compare the third stage with the second, never the first
	wire stb_a_fall = phs_fall(c_s3[`PHS_C_STB_A], strobe_in_grp_a_n);
	wire stb_b_fall = phs_fall(c_s3[`PHS_C_STB_B], strobe_in_grp_b_n);
	wire ack_a_fall = phs_fall(c_s3[`PHS_C_ACK_A], acknowledge_grp_a_n);
	wire ack_b_fall = phs_fall(c_s3[`PHS_C_ACK_B], acknowledge_grp_b_n);
	// R16 request while enabled and input full, or enabled and output empty
	wire irq_request_grp_a = phs_irq(irq_enable_grp_a, dir_a_in, input_full_grp_a, output_full_grp_a_n);
	wire irq_request_grp_b = phs_irq(irq_enable_grp_b, dir_b_in, input_full_grp_b, output_full_grp_b_n);

	// ahb address phase decode
	// only the low nibble selects a register; anything above it is unmapped
	wire addr_ok = i_hsel & i_htrans[1] & i_hready;
	wire [3:0] ofs = i_haddr[3:0];
	wire in_map = (i_haddr[31:4] == 28'h0000000);
	wire rd_take = addr_ok & ~i_hwrite & in_map;
	wire rd_a = rd_take & phs_hit(ofs, `PHS_OFS_PORT_A);
	wire rd_b = rd_take & phs_hit(ofs, `PHS_OFS_PORT_B);
	// data phase write strobes, hwdata stands only in the data phase
	wire wr_a = wr_pend & phs_hit(wr_ofs, `PHS_OFS_PORT_A);
	wire wr_b = wr_pend & phs_hit(wr_ofs, `PHS_OFS_PORT_B);
	wire wr_c = wr_pend & phs_hit(wr_ofs, `PHS_OFS_PORT_C);
	wire wr_ctrl = wr_pend & phs_hit(wr_ofs, `PHS_OFS_CTRL);
	wire [7:0] wdat = i_hwdata[7:0];
	// R1 mode word versus R21 bit set/reset
	wire wr_mode = wr_ctrl & wdat[`PHS_CW_FLAG];
	wire wr_bsr = wr_ctrl & ~wdat[`PHS_CW_FLAG];
	wire [2:0] bsr_sel = wdat[3:1];
	wire bsr_val = wdat[`PHS_CW_BIT_VAL];

	// status word and pin enables per group
	// handshake outputs follow the flags here and pass one flop to the pins
	always @* begin
		status_c = 8'h00;
		next_c_out = out_c;
		next_c_oe = 8'h00;
		next_a_oe = 8'h00;
		next_b_oe = 8'h00;
		// R2 basic directions, R3 independent nibbles, R4 live input reads
		next_c_oe[7:4] = dir_cu_in ? 4'h0 : 4'hF;
		next_c_oe[3:0] = dir_cl_in ? 4'h0 : 4'hF;
		status_c[7:4] = dir_cu_in ? c_s2[7:4] : out_c[7:4];
		status_c[3:0] = dir_cl_in ? c_s2[3:0] : out_c[3:0];
		if (!dir_a_in) begin
			next_a_oe = 8'hFF;
		end
		if (!dir_b_in) begin
			next_b_oe = 8'hFF;
		end
		if (ga_strobed) begin
			// R6 group A takes line 3 plus two lines of the upper nibble
			if (dir_a_in) begin
				// R11 R10 input lines, R12 R13 status without strobe
				next_c_out[`PHS_C_FULL_A_IN] = input_full_grp_a;
				next_c_out[`PHS_C_REQ_A] = irq_request_grp_a;
				next_c_oe[5:3] = 3'h5;
				status_c[5:3] = {input_full_grp_a, irq_enable_grp_a, irq_request_grp_a};
			end else begin
				// R22 R18 output lines, R20 output layout
				next_c_out[`PHS_C_FULL_A_OUT] = output_full_grp_a_n;
				next_c_out[`PHS_C_REQ_A] = irq_request_grp_a;
				next_c_oe[7:6] = 2'h2;
				next_c_oe[3] = 1'b1;
				status_c[7:6] = {output_full_grp_a_n, irq_enable_grp_a};
				status_c[3] = irq_request_grp_a;
			end
		end
		// group B keeps enable, full and request on the same lines both ways
		if (gb_strobed) begin
			// R9 R19 group B owns lines 2..0, no spares
			next_c_oe[2:0] = 3'h3;
			next_c_out[`PHS_C_REQ_B] = irq_request_grp_b;
			if (dir_b_in) begin
				next_c_out[`PHS_C_FULL_B] = input_full_grp_b;
				status_c[2:0] = {irq_enable_grp_b, input_full_grp_b, irq_request_grp_b};
			end else begin
				next_c_out[`PHS_C_FULL_B] = output_full_grp_b_n;
				status_c[2:0] = {irq_enable_grp_b, output_full_grp_b_n, irq_request_grp_b};
			end
		end
	end

	// read data mux
	// control and unmapped offsets read back as zero
	always @* begin
		rd_val = 8'h00;
		case (ofs)
			`PHS_OFS_PORT_A: begin
				// R7 strobed input reads the latch
				if (dir_a_in) begin
					rd_val = ga_strobed ? in_latch_a : a_s2;
				end else begin
					rd_val = out_a;
				end
			end
			`PHS_OFS_PORT_B: begin
				// strobed input reads its latch, basic input the live pins
				if (dir_b_in) begin
					rd_val = gb_strobed ? in_latch_b : b_s2;
				end else begin
					rd_val = out_b;
				end
			end
			`PHS_OFS_PORT_C: begin
				rd_val = status_c;
			end
			default: begin
				rd_val = 8'h00;
			end
		endcase
	end

	// pin synchronisers
	// c lines reset high like the pulled-up idle level, so no false edge follows
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			a_s1 <= 8'h00;
			a_s2 <= 8'h00;
			b_s1 <= 8'h00;
			b_s2 <= 8'h00;
			c_s1 <= 8'hFF;
			c_s2 <= 8'hFF;
			c_s3 <= 8'hFF;
		end else begin
			a_s1 <= i_port_a;
			a_s2 <= a_s1;
			b_s1 <= i_port_b;
			b_s2 <= b_s1;
			c_s1 <= i_port_c;
			c_s2 <= c_s1;
			c_s3 <= c_s2;
		end
	end

	// ahb slave: zero wait states, always okay
	// read data loads at the address-phase edge and stands through the data phase
	// any other taken transfer zeroes it so a stale byte never shows
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_hrdata <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_ofs <= 4'h0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			wr_pend <= addr_ok & i_hwrite & in_map;
			wr_ofs <= ofs;
			if (rd_take) begin
				o_hrdata <= {24'h000000, rd_val};
			end else if (addr_ok) begin
				o_hrdata <= 32'h00000000;
			end
		end
	end

	// mode word, latches and handshake flags
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			mode_word <= `PHS_MODE_RESET;
			out_a <= 8'h00;
			out_b <= 8'h00;
			out_c <= 8'h00;
			in_latch_a <= 8'h00;
			in_latch_b <= 8'h00;
			input_full_grp_a <= 1'b0;
			input_full_grp_b <= 1'b0;
			output_full_grp_a_n <= 1'b1;
			output_full_grp_b_n <= 1'b1;
			irq_enable_grp_a <= 1'b0;
			irq_enable_grp_b <= 1'b0;
		end else if (wr_mode) begin
			// R26 mode word clears latches and flags
			// a mode word overrides every other event in its cycle
			mode_word <= wdat;
			out_a <= 8'h00;
			out_b <= 8'h00;
			out_c <= 8'h00;
			in_latch_a <= 8'h00;
			in_latch_b <= 8'h00;
			input_full_grp_a <= 1'b0;
			input_full_grp_b <= 1'b0;
			output_full_grp_a_n <= 1'b1;
			output_full_grp_b_n <= 1'b1;
			irq_enable_grp_a <= 1'b0;
			irq_enable_grp_b <= 1'b0;
		end else begin
			// R4 R5 output latches load directly
			if (wr_a) begin
				out_a <= wdat;
			end
			if (wr_b) begin
				out_b <= wdat;
			end
			if (wr_c) begin
				out_c <= wdat;
			end
			// R17 R21 single bit set/reset, enables in strobed groups
			// the selected bit also loads the C latch so plain lines follow it
			if (wr_bsr) begin
				out_c[bsr_sel] <= bsr_val;
				if (ga_strobed && ((dir_a_in && bsr_sel == `PHS_BSR_ENA_IN) ||
					(!dir_a_in && bsr_sel == `PHS_BSR_ENA_OUT))) begin
					irq_enable_grp_a <= bsr_val;
				end
				if (gb_strobed && bsr_sel == `PHS_BSR_ENB) begin
					irq_enable_grp_b <= bsr_val;
				end
			end
			// R25 R14 strobe loads latch, set beats read clear
			// a strobe in the cycle of a data read keeps the buffer full
			if (ga_strobed && dir_a_in) begin
				if (stb_a_fall) begin
					in_latch_a <= a_s2;
					input_full_grp_a <= 1'b1;
				end else if (rd_a) begin
					input_full_grp_a <= 1'b0;
				end
			end
			if (gb_strobed && dir_b_in) begin
				if (stb_b_fall) begin
					in_latch_b <= b_s2;
					input_full_grp_b <= 1'b1;
				end else if (rd_b) begin
					input_full_grp_b <= 1'b0;
				end
			end
			// R23 host write drops full, acknowledge raises it
			// a host write in the cycle of an acknowledge keeps the buffer full
			if (ga_strobed && !dir_a_in) begin
				if (wr_a) begin
					output_full_grp_a_n <= 1'b0;
				end else if (ack_a_fall) begin
					output_full_grp_a_n <= 1'b1;
				end
			end
			if (gb_strobed && !dir_b_in) begin
				if (wr_b) begin
					output_full_grp_b_n <= 1'b0;
				end else if (ack_b_fall) begin
					output_full_grp_b_n <= 1'b1;
				end
			end
		end
	end

	// registered pin drivers
	// pins lag the latches and flags by one cycle
	// enables stay low through reset so no line is driven before a mode word
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_port_a <= 8'h00;
			o_port_a_oe <= 8'h00;
			o_port_b <= 8'h00;
			o_port_b_oe <= 8'h00;
			o_port_c <= 8'h00;
			o_port_c_oe <= 8'h00;
		end else begin
			o_port_a <= out_a;
			o_port_a_oe <= next_a_oe;
			o_port_b <= out_b;
			o_port_b_oe <= next_b_oe;
			o_port_c <= next_c_out;
			o_port_c_oe <= next_c_oe;
		end
	end

endmodule // phs_port
